// ### eifs_pkg.sv
// eifs_pkg: shared constants and types for the event input function unit.
// assumes one 40 MHz controller clock and an AHB-Lite register bus.
package eifs_pkg;

  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int VAL_W   = 16;
  localparam int FN_W    = 4;
  localparam int ADDR_W  = 8;
  localparam int CLK_MHZ = 40;

  // ----------------------------------------
  // event function codes
  // ----------------------------------------
  typedef enum logic [FN_W-1:0] {
    EIFS_FN_NONE      = 4'h0,
    EIFS_FN_SP_SWAP   = 4'h1,
    EIFS_FN_GAIN_SWAP = 4'h2,
    EIFS_FN_COMBINED  = 4'h3,
    EIFS_FN_CLR_A1    = 4'h4,
    EIFS_FN_CLR_A2    = 4'h5,
    EIFS_FN_CLR_BOTH  = 4'h6,
    EIFS_FN_MUTE1     = 4'h7,
    EIFS_FN_MUTE2     = 4'h8,
    EIFS_FN_MUTE_BOTH = 4'h9,
    EIFS_FN_LOCK      = 4'hA
  } eifs_fn_t;

  // ----------------------------------------
  // bus slave states
  // ----------------------------------------
  typedef enum logic [1:0] {
    EIFS_BUS_IDLE  = 2'b00,
    EIFS_BUS_WRITE = 2'b01,
    EIFS_BUS_RWAIT = 2'b10,
    EIFS_BUS_RDONE = 2'b11
  } eifs_bus_t;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRI_SP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SEC_SP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BAND_A = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INTG_A = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DRV_A  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_BAND_B = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_INTG_B = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_DRV_B  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h2C;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_FN_LSB  = 0;
  localparam int CTRL_FMT_BIT = 4;
  localparam int ST_ABORT     = 0;
  localparam int ST_ALM1      = 1;
  localparam int ST_ALM2      = 2;
  localparam int ST_ACT       = 3;
  localparam int ST_REL       = 4;
  localparam int ST_W         = 5;
  localparam logic [VAL_W-1:0] RST_VAL  = 16'h0000;
  localparam logic [FN_W-1:0]  RST_FN   = 4'h0;
  localparam logic [ST_W-1:0]  RST_MASK = 5'h00;

endpackage

// ### eifs_sync.sv
// eifs_sync: two-stage synchroniser with activation and release edges.
// assumes the raw event level may change at any time.
`timescale 1ns/1ps
module eifs_sync (
  input  wire logic sys_clk, // controller clock
  input  wire logic reset,   // synchronous, active high
  input  wire logic din,     // raw event level
  output logic      level,   // synchronised level
  output logic      rise,    // one-cycle activation pulse
  output logic      fall     // one-cycle release pulse
);
  logic meta;
  logic prev;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= din;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

  a_edge_rise: assert property (@(posedge sys_clk) disable iff (reset)
    rise |-> level && !$past(level)) else $error("rise without level change");
  a_edge_fall: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(level) |-> fall) else $error("release edge missed");
endmodule

// ### eifs_alarm_latch.sv
// eifs_alarm_latch: latching alarm or dwell output with event reset.
// assumes cond is the live alarm condition from the alarm logic.
`timescale 1ns/1ps
module eifs_alarm_latch (
  input  wire logic sys_clk,  // controller clock
  input  wire logic reset,    // synchronous, active high
  input  wire logic cond,     // alarm or timeout condition
  input  wire logic clear_fn, // a clearing function is selected
  input  wire logic evt,      // synchronised event level
  input  wire logic act,      // activation pulse
  output logic      latched,  // alarm output
  output logic      raised    // pulse when alarm becomes set
);
  wire hold_off  = clear_fn & evt;
  wire do_clear  = clear_fn & act;
  wire set_cond  = cond & ~hold_off;
  wire next_latched = do_clear ? 1'b0 : (set_cond | latched);

  assign raised = ~latched & next_latched;

  always_ff @(posedge sys_clk) begin
    if (reset) latched <= 1'b0;
    else latched <= next_latched;
  end

  sequence s_release_with_cond;
    clear_fn && $fell(evt) && cond;
  endsequence

  a_clear_on_act: assert property (@(posedge sys_clk) disable iff (reset)
    do_clear |=> !latched) else $error("alarm not reset on activation");
  a_retrig_release: assert property (@(posedge sys_clk) disable iff (reset)
    s_release_with_cond |=> latched) else $error("alarm not retriggered");
  a_dwell_holds: assert property (@(posedge sys_clk) disable iff (reset)
    latched && !do_clear |=> latched) else $error("latched output dropped");
endmodule

// ### eifs_core.sv
// eifs_core: event input function unit with AHB-Lite register slave.
// assumes a single bus master, whole-word single transfers, one clock.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module eifs_core
  import eifs_pkg::*;
(
  input  wire logic                     sys_clk,        // controller clock
  input  wire logic                     reset,          // synchronous, high
  input  wire logic                     hsel,           // slave select
  input  wire logic [31:0]              haddr,          // byte address
  input  wire logic [1:0]               htrans,         // transfer type
  input  wire logic                     hwrite,         // write request
  input  wire logic [2:0]               hsize,          // word only
  input  wire logic [31:0]              hwdata,         // write data
  input  wire logic                     hready,         // bus ready
  output logic      [31:0]              hrdata,         // read data
  output logic                          hreadyout,      // slave ready
  output logic                          hresp,          // always okay
  input  wire logic                     event_in,       // raw event level
  input  wire logic                     alarm_one_cond, // alarm one condition
  input  wire logic                     alarm_two_cond, // alarm two condition
  input  wire logic                     tune_active,    // tuning running
  input  wire logic                     tune_done,      // tuning finished
  input  wire logic [eifs_pkg::VAL_W-1:0] tune_pb,      // found band
  input  wire logic [eifs_pkg::VAL_W-1:0] tune_ti,      // found integral
  input  wire logic [eifs_pkg::VAL_W-1:0] tune_td,      // found derivative
  input  wire logic [eifs_pkg::VAL_W-1:0] demand_one_in, // loop demand one
  input  wire logic [eifs_pkg::VAL_W-1:0] demand_two_in, // loop demand two
  output logic [eifs_pkg::VAL_W-1:0]    active_setpoint, // set point in use
  output logic [eifs_pkg::VAL_W-1:0]    active_prop_band, // band in use
  output logic [eifs_pkg::VAL_W-1:0]    active_integral, // integral in use
  output logic [eifs_pkg::VAL_W-1:0]    active_derivative, // derivative in use
  output logic [eifs_pkg::VAL_W-1:0]    out_one_demand, // demand to output 1
  output logic [eifs_pkg::VAL_W-1:0]    out_two_demand, // demand to output 2
  output logic                          alarm_one,      // alarm one output
  output logic                          alarm_two,      // alarm two output
  output logic                          tune_abort,     // tuning error pulse
  output logic                          irq             // interrupt level
);
  import eifs_pkg::*;

  // ----------------------------------------
  // configuration and parameter registers
  // ----------------------------------------
  logic [FN_W-1:0]  event_function_select;
  logic             secondary_setpoint_format;
  logic [VAL_W-1:0] primary_setpoint;
  logic [VAL_W-1:0] secondary_setpoint;
  logic [VAL_W-1:0] first_prop_band;
  logic [VAL_W-1:0] first_integral_time;
  logic [VAL_W-1:0] first_derivative_time;
  logic [VAL_W-1:0] second_prop_band;
  logic [VAL_W-1:0] second_integral_time;
  logic [VAL_W-1:0] second_derivative_time;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  mask;

  // ----------------------------------------
  // event input
  // ----------------------------------------
  logic evt;
  logic evt_act;
  logic evt_rel;

  eifs_sync u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (event_in),
    .level   (evt),
    .rise    (evt_act),
    .fall    (evt_rel)
  );

  // ----------------------------------------
  // function decode
  // ----------------------------------------
  wire fn_sp    = event_function_select == EIFS_FN_SP_SWAP;
  wire fn_gain  = event_function_select == EIFS_FN_GAIN_SWAP;
  wire fn_comb  = event_function_select == EIFS_FN_COMBINED;
  wire fn_ca1   = event_function_select == EIFS_FN_CLR_A1;
  wire fn_ca2   = event_function_select == EIFS_FN_CLR_A2;
  wire fn_cab   = event_function_select == EIFS_FN_CLR_BOTH;
  wire fn_m1    = event_function_select == EIFS_FN_MUTE1;
  wire fn_m2    = event_function_select == EIFS_FN_MUTE2;
  wire fn_mb    = event_function_select == EIFS_FN_MUTE_BOTH;
  wire fn_lock  = event_function_select == EIFS_FN_LOCK;

  // no-function and the other codes leave both selections off
  wire use_sec_sp = evt & (fn_sp | fn_comb);
  wire use_gain2 = evt & (fn_gain | fn_comb);
  wire mute_one  = evt & (fn_m1 | fn_mb);
  wire mute_two  = evt & (fn_m2 | fn_mb);
  wire locked    = evt & fn_lock;

  // offset sum wraps at the value width; range limits belong to the loop
  wire [VAL_W-1:0] offset_sum = VAL_W'(primary_setpoint + secondary_setpoint);
  wire [VAL_W-1:0] second_sp = secondary_setpoint_format ? offset_sum
                                                         : secondary_setpoint;
  wire [VAL_W-1:0] next_sp  = use_sec_sp ? second_sp : primary_setpoint;
  wire [VAL_W-1:0] next_pb  = use_gain2 ? second_prop_band : first_prop_band;
  wire [VAL_W-1:0] next_ti  = use_gain2 ? second_integral_time : first_integral_time;
  wire [VAL_W-1:0] next_td  = use_gain2 ? second_derivative_time : first_derivative_time;

  // set-point source change while tuning is running
  wire sp_src_flip = (evt_act | evt_rel) & (fn_sp | fn_comb);
  wire next_abort  = tune_active & sp_src_flip;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active_setpoint   <= RST_VAL;
      active_prop_band  <= RST_VAL;
      active_integral   <= RST_VAL;
      active_derivative <= RST_VAL;
      out_one_demand    <= RST_VAL;
      out_two_demand    <= RST_VAL;
      tune_abort        <= 1'b0;
    end else begin
      active_setpoint   <= next_sp;
      active_prop_band  <= next_pb;
      active_integral   <= next_ti;
      active_derivative <= next_td;
      out_one_demand    <= mute_one ? RST_VAL : demand_one_in;
      out_two_demand    <= mute_two ? RST_VAL : demand_two_in;
      tune_abort        <= next_abort;
    end
  end

  // ----------------------------------------
  // alarms
  // ----------------------------------------
  logic alm1_raised;
  logic alm2_raised;

  eifs_alarm_latch u_alarm_one (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .cond     (alarm_one_cond),
    .clear_fn (fn_ca1 | fn_cab),
    .evt      (evt),
    .act      (evt_act),
    .latched  (alarm_one),
    .raised   (alm1_raised)
  );

  eifs_alarm_latch u_alarm_two (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .cond     (alarm_two_cond),
    .clear_fn (fn_ca2 | fn_cab),
    .evt      (evt),
    .act      (evt_act),
    .latched  (alarm_two),
    .raised   (alm2_raised)
  );

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  eifs_bus_t        bus_state;
  logic [ADDR_W-1:0] addr_q;

  wire accept   = hsel & htrans[1] & hready;
  wire wr_phase = bus_state == EIFS_BUS_WRITE;
  wire [ADDR_W-1:0] a_word = {addr_q[ADDR_W-1:2], 2'b00};
  wire cfg_we   = wr_phase & ~locked;
  wire we_ctrl  = cfg_we & (a_word == OFS_CTRL);
  wire we_psp    = cfg_we & (a_word == OFS_PRI_SP);
  wire we_ssp    = cfg_we & (a_word == OFS_SEC_SP);
  wire we_band_a = cfg_we & (a_word == OFS_BAND_A);
  wire we_intg_a = cfg_we & (a_word == OFS_INTG_A);
  wire we_drv_a  = cfg_we & (a_word == OFS_DRV_A);
  wire we_band_b = cfg_we & (a_word == OFS_BAND_B);
  wire we_intg_b = cfg_we & (a_word == OFS_INTG_B);
  wire we_drv_b  = cfg_we & (a_word == OFS_DRV_B);
  // status and mask stay reachable under lock so software can service irq
  wire we_stat  = wr_phase & (a_word == OFS_STATUS);
  wire we_mask  = wr_phase & (a_word == OFS_MASK);

  // reads pay one wait state so a write just before is always visible
  assign hreadyout = bus_state != EIFS_BUS_RWAIT;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_state <= EIFS_BUS_IDLE;
      addr_q    <= '0;
    end else begin
      case (bus_state)
        EIFS_BUS_RWAIT: bus_state <= EIFS_BUS_RDONE;
        default: begin
          if (accept) begin
            addr_q    <= haddr[ADDR_W-1:0];
            bus_state <= hwrite ? EIFS_BUS_WRITE : EIFS_BUS_RWAIT;
          end else begin
            bus_state <= EIFS_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // register updates
  // ----------------------------------------
  // a finished tuning run wins over a bus write to the same gain word
  wire tune_g1 = tune_done & ~use_gain2;
  wire tune_g2 = tune_done & use_gain2;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      event_function_select     <= RST_FN;
      secondary_setpoint_format <= 1'b0;
      primary_setpoint          <= RST_VAL;
      secondary_setpoint        <= RST_VAL;
      mask                      <= RST_MASK;
    end else begin
      if (we_ctrl) begin
        event_function_select     <= hwdata[CTRL_FN_LSB +: FN_W];
        secondary_setpoint_format <= hwdata[CTRL_FMT_BIT];
      end
      if (we_psp) primary_setpoint <= hwdata[VAL_W-1:0];
      if (we_ssp) secondary_setpoint <= hwdata[VAL_W-1:0];
      if (we_mask) mask <= hwdata[ST_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      first_prop_band        <= RST_VAL;
      first_integral_time    <= RST_VAL;
      first_derivative_time  <= RST_VAL;
      second_prop_band       <= RST_VAL;
      second_integral_time   <= RST_VAL;
      second_derivative_time <= RST_VAL;
    end else begin
      if (tune_g1) begin
        first_prop_band       <= tune_pb;
        first_integral_time   <= tune_ti;
        first_derivative_time <= tune_td;
      end else begin
        if (we_band_a) first_prop_band <= hwdata[VAL_W-1:0];
        if (we_intg_a) first_integral_time <= hwdata[VAL_W-1:0];
        if (we_drv_a) first_derivative_time <= hwdata[VAL_W-1:0];
      end
      if (tune_g2) begin
        second_prop_band       <= tune_pb;
        second_integral_time   <= tune_ti;
        second_derivative_time <= tune_td;
      end else begin
        if (we_band_b) second_prop_band <= hwdata[VAL_W-1:0];
        if (we_intg_b) second_integral_time <= hwdata[VAL_W-1:0];
        if (we_drv_b) second_derivative_time <= hwdata[VAL_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  wire [ST_W-1:0] events = {evt_rel, evt_act, alm2_raised, alm1_raised, next_abort};
  wire [ST_W-1:0] w1c    = we_stat ? hwdata[ST_W-1:0] : '0;
  // a new event in the clearing cycle survives the clear
  wire [ST_W-1:0] next_status = (status & ~w1c) | events;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] rd_ctrl  = {27'h0, secondary_setpoint_format, event_function_select};
  wire [31:0] rd_state = {26'h0, locked, use_gain2, use_sec_sp, alarm_two, alarm_one, evt};
  logic [31:0] rd_mux;

  always_comb begin
    case (a_word)
      OFS_CTRL:   rd_mux = rd_ctrl;
      OFS_PRI_SP: rd_mux = {16'h0, primary_setpoint};
      OFS_SEC_SP: rd_mux = {16'h0, secondary_setpoint};
      OFS_BAND_A: rd_mux = {16'h0, first_prop_band};
      OFS_INTG_A: rd_mux = {16'h0, first_integral_time};
      OFS_DRV_A:  rd_mux = {16'h0, first_derivative_time};
      OFS_BAND_B: rd_mux = {16'h0, second_prop_band};
      OFS_INTG_B: rd_mux = {16'h0, second_integral_time};
      OFS_DRV_B:  rd_mux = {16'h0, second_derivative_time};
      OFS_STATE:  rd_mux = rd_state;
      OFS_STATUS: rd_mux = {27'h0, status};
      OFS_MASK:   rd_mux = {27'h0, mask};
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) hrdata <= 32'h0;
    else if (bus_state == EIFS_BUS_RWAIT) hrdata <= rd_mux;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_gain2_tune;
    tune_done && use_gain2;
  endsequence

  a_idle_primary: assert property (@(posedge sys_clk) disable iff (reset)
    event_function_select == EIFS_FN_NONE ##1 event_function_select == EIFS_FN_NONE
    |-> active_setpoint == $past(primary_setpoint)
        && active_prop_band == $past(first_prop_band))
    else $error("no-function did not use primary values");
  a_sp_swap: assert property (@(posedge sys_clk) disable iff (reset)
    use_sec_sp && !secondary_setpoint_format |=> active_setpoint == $past(secondary_setpoint))
    else $error("second set point not used");
  a_gain_swap: assert property (@(posedge sys_clk) disable iff (reset)
    use_gain2 |=> active_integral == $past(second_integral_time))
    else $error("second gain set not used");
  a_combined: assert property (@(posedge sys_clk) disable iff (reset)
    fn_comb && evt && !secondary_setpoint_format
    |=> active_setpoint == $past(secondary_setpoint)
        && active_prop_band == $past(second_prop_band))
    else $error("combined swap incomplete");
  a_tune_store: assert property (@(posedge sys_clk) disable iff (reset)
    s_gain2_tune |=> second_prop_band == $past(tune_pb)
                     && first_prop_band == $past(first_prop_band))
    else $error("tuning result stored in wrong set");
  a_mute_one: assert property (@(posedge sys_clk) disable iff (reset)
    mute_one |=> out_one_demand == 16'h0000)
    else $error("output one not muted");
  a_mute_two: assert property (@(posedge sys_clk) disable iff (reset)
    (fn_m2 || fn_mb) && evt |=> out_two_demand == 16'h0000)
    else $error("output two not muted");
  a_mute_release: assert property (@(posedge sys_clk) disable iff (reset)
    fn_m1 && evt_rel |=> out_one_demand == $past(demand_one_in))
    else $error("output one not restored");
  a_lock_hold: assert property (@(posedge sys_clk) disable iff (reset)
    wr_phase && locked |=> $stable(primary_setpoint) && $stable(event_function_select))
    else $error("write accepted under lock");
  a_offset_sp: assert property (@(posedge sys_clk) disable iff (reset)
    use_sec_sp && secondary_setpoint_format
    |=> active_setpoint == 16'($past(primary_setpoint) + $past(secondary_setpoint)))
    else $error("offset set point wrong");
  a_abort_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    tune_active && fn_sp && evt_act |=> tune_abort && status[ST_ABORT])
    else $error("tuning not aborted");
endmodule

// ### eifs_evt_src.sv
// eifs_evt_src: far-side event source, a switch or relay contact.
// assumes the bench moves cmd just after a clock edge.
`timescale 1ns/1ps
module eifs_evt_src (
  input  wire logic sys_clk,         // controller clock
  input  wire logic cmd,             // wanted contact state
  output logic      event_in = 1'b0  // contact level, open at start
);
  // contact follows one cycle late, like a relay
  always @(posedge sys_clk) begin
    event_in <= cmd;
  end
endmodule

// ### tb_event_input_function_select.sv
// tb_event_input_function_select: register-level tests of the event unit.
// assumes eifs_core as sole AHB slave, the contact model as event source.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_event_input_function_select;
  import eifs_pkg::*;
  logic             sys_clk = 0, reset = 1, hsel = 0, hwrite = 0, hready, hresp, irq;
  logic [31:0]      haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0]       htrans = 0;
  logic             ev_cmd = 0, ev, a1c = 0, a2c = 0, t_act = 0, t_done = 0, al1, al2, ab;
  logic [VAL_W-1:0] t_pb = 0, d1 = 16'h0AAA, d2 = 16'h0BBB, sp, pb, ti, td, o1, o2;
  int               n_errors = 0, n_compared = 0, n_ab = 0;
  always #12.5 sys_clk = ~sys_clk;
  // abort is a one-cycle pulse, so count it as it passes
  always @(posedge sys_clk) if (ab === 1'b1) n_ab <= n_ab + 1;
  eifs_evt_src u_src (.sys_clk(sys_clk), .cmd(ev_cmd), .event_in(ev));
  eifs_core u_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .event_in(ev),
    .alarm_one_cond(a1c), .alarm_two_cond(a2c), .tune_active(t_act), .tune_done(t_done),
    .tune_pb(t_pb), .tune_ti(t_pb), .tune_td(t_pb), .demand_one_in(d1), .demand_two_in(d2),
    .active_setpoint(sp), .active_prop_band(pb), .active_integral(ti), .active_derivative(td),
    .out_one_demand(o1), .out_two_demand(o2), .alarm_one(al1), .alarm_two(al2),
    .tune_abort(ab), .irq(irq));
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // bounded wait for hready sampled high at an edge
  task rdy;
    int i;
    i = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1) begin
      if (++i > 40) begin n_errors++; test_done; end
      @(posedge sys_clk);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    rdy;
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    rdy;
    rv = hrdata;
  endtask
  task evt(input logic v);
    ev_cmd <= v;
    cyc(6);
  endtask
  // fresh activation under the new function, not a mid-level swap
  task sel(input eifs_fn_t f, input logic fmt);
    evt(0);
    xfer(1, OFS_CTRL, {27'h0, fmt, f});
    evt(1);
  endtask
  initial begin
    cyc(10);
    reset <= 0;
    xfer(0, OFS_CTRL, 0); `CHK("ctrl", 32'h0, rv)
    `CHK("hresp", 1'b0, hresp)
    xfer(0, 8'h40, 0); `CHK("unmapped", 32'h0, rv)
    xfer(0, OFS_MASK, 0); `CHK("mask", 32'h0, rv)
    xfer(1, OFS_PRI_SP, 32'h100);
    xfer(1, OFS_SEC_SP, 32'h20);
    xfer(1, OFS_BAND_A, 32'h11);
    xfer(1, OFS_BAND_B, 32'h22);
    $display("test registers done");
    sel(EIFS_FN_NONE, 0); `CHK("sp", 16'h0100, sp)
    `CHK("pb", 16'h0011, pb)
    sel(EIFS_FN_SP_SWAP, 0); `CHK("sp", 16'h0020, sp)
    sel(EIFS_FN_SP_SWAP, 1); `CHK("sp", 16'h0120, sp)
    sel(EIFS_FN_GAIN_SWAP, 0); `CHK("pb", 16'h0022, pb)
    `CHK("sp", 16'h0100, sp)
    sel(EIFS_FN_COMBINED, 0); `CHK("sp", 16'h0020, sp)
    `CHK("pb", 16'h0022, pb)
    t_pb <= 16'h0055; t_done <= 1; cyc(1); t_done <= 0;
    xfer(0, OFS_BAND_B, 0); `CHK("sec band", 32'h55, rv)
    `CHK("ti", 16'h0055, ti)
    `CHK("td", 16'h0055, td)
    t_act <= 1; sel(EIFS_FN_SP_SWAP, 0); t_act <= 0;
    xfer(0, OFS_STATUS, 0); `CHK("abort", 1'b1, rv[ST_ABORT])
    `CHK("abort pulses", 2, n_ab)
    $display("test selection done");
    sel(EIFS_FN_MUTE1, 0); `CHK("o1", 16'h0, o1)
    `CHK("o2", d2, o2)
    sel(EIFS_FN_MUTE2, 0); `CHK("o2", 16'h0, o2)
    `CHK("o1", d1, o1)
    sel(EIFS_FN_MUTE_BOTH, 0); `CHK("o12", 32'h0, {o1, o2})
    evt(0); `CHK("o12", {d1, d2}, {o1, o2})
    a1c <= 1; a2c <= 1; sel(EIFS_FN_CLR_A1, 0); `CHK("al1", 1'b0, al1)
    `CHK("al2", 1'b1, al2)
    evt(0); `CHK("al1", 1'b1, al1)
    sel(EIFS_FN_CLR_A2, 0); `CHK("al2", 1'b0, al2)
    a2c <= 0; evt(0); `CHK("al2", 1'b0, al2)
    a2c <= 1; cyc(4); sel(EIFS_FN_CLR_BOTH, 0); `CHK("al12", 2'h0, {al1, al2})
    a2c <= 0; evt(0); `CHK("al12", 2'h2, {al1, al2})
    a1c <= 0; sel(EIFS_FN_NONE, 0); `CHK("al1", 1'b1, al1)
    $display("test outputs done");
    evt(0);
    xfer(1, OFS_STATUS, 32'h1F);
    xfer(1, OFS_MASK, 32'h08); cyc(2); `CHK("irq", 1'b0, irq)
    evt(1); `CHK("irq", 1'b1, irq)
    xfer(1, OFS_STATUS, 32'h08); cyc(2); `CHK("irq", 1'b0, irq)
    sel(EIFS_FN_LOCK, 0); xfer(1, OFS_PRI_SP, 32'h999);
    xfer(0, OFS_PRI_SP, 0); `CHK("pri sp", 32'h100, rv)
    evt(0); xfer(1, OFS_PRI_SP, 32'h999);
    xfer(0, OFS_PRI_SP, 0); `CHK("pri sp", 32'h999, rv)
    $display("test irq and lock done");
    test_done;
  end
endmodule
